// >>> verilog/btg_pkg.sv
// Package for the buzzer tone generator: register map, fields, patterns, timing.
// Assumes a 32-bit classic Wishbone bus and a 100 MHz system clock.
package btg_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CONTROL = 16'hF2C0;
   localparam logic [15:0] IDX_PATTERN = 16'hF2C1;
   localparam logic [15:0] IDX_PITCH = 16'hF2C2;
   localparam logic [15:0] IDX_DUTY = 16'hF2C3;
   localparam int ADR_W = 18;
   localparam int DAT_W = 32;
   localparam int SEL_W = 4;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_LEVEL_BIT = 1;
   localparam int PAT_LSB = 0;
   localparam int PITCH_LSB = 0;
   localparam int DUTY_LSB = 0;
   localparam int WORD_DUTY_LSB = 8;
   localparam int LANE_LO = 0;
   localparam int LANE_HI = 1;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [DAT_W-1:0] DAT_ZERO = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Sound patterns
   typedef enum logic [1:0] {
      PAT_INT1 = 2'h0,
      PAT_INT2 = 2'h1,
      PAT_SINGLE = 2'h2,
      PAT_CONT = 2'h3
   } btg_pattern_t;

   typedef struct packed {
      logic run;
      logic [1:0] pattern;
      logic [2:0] pitch;
      logic [3:0] duty;
   } btg_cfg_t;

   ////////////////////////////////////////////////////////////////////////////
   // Timing: tone base is the doubled low-speed rate over sixteen phases
   localparam int CLK_HZ = 100_000_000;
   localparam int LS_NOMINAL_HZ = 32_768;
   localparam int DBL_FACTOR = 2;
   localparam int DBL_HZ = LS_NOMINAL_HZ * DBL_FACTOR;
   localparam int PHASES = 16;
   localparam int PITCH_BASE_HZ = DBL_HZ / PHASES;
   localparam logic [3:0] PHASE_LAST = 4'(PHASES - 1);
   localparam int ENV_W = 16;

   // High phases out of sixteen; code 0 behaves as code 1
   function automatic logic [4:0] high_phases(input logic [3:0] duty);
      high_phases = (duty == 4'h0) ? 5'h01 : {1'b0, duty};
   endfunction

endpackage

// >>> verilog/btg_tone.sv
// Tone divider: sixteen phases per period, each phase lasting pitch+1 ticks.
// Assumes one-cycle tick pulses at the doubled low-speed rate.
`timescale 1ns/100ps
module btg_tone (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic enable,
   input wire logic [2:0] pitch,
   input wire logic [3:0] duty,
   output logic level_q
);
   logic [2:0] div_q;
   logic [3:0] phase_q;

   ////////////////////////////////////////////////////////////////////////////
   // Divider restarts while idle so each burst opens on a high phase
   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         div_q <= 3'h0;
      end else if (tick) begin
         div_q <= (div_q >= pitch) ? 3'h0 : div_q + 3'h1; // [RULE5] [RULE6]
      end
   end

   always_ff @(posedge clk) begin
      if (rst || !enable) begin
         phase_q <= 4'h0;
      end else if (tick && div_q >= pitch) begin
         phase_q <= (phase_q == btg_pkg::PHASE_LAST) ? 4'h0 : phase_q + 4'h1; // [RULE5]
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b0;
      end else begin
         level_q <= enable && ({1'b0, phase_q} < btg_pkg::high_phases(duty)); // [RULE7] [RULE8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_high_phase: assert property (level_q |-> // [RULE7]
      {1'b0, $past(phase_q)} < btg_pkg::high_phases($past(duty)))
      else $error("tone high outside duty phases");
   a_phase_step: assert property ($past(enable) && $changed(phase_q) |-> // [RULE5]
      $past(tick) && $past(div_q) >= $past(pitch))
      else $error("phase advanced without full divide");
endmodule

// >>> verilog/btg_env.sv
// Pattern envelope: gates the tone on and off per the selected sound pattern.
// Assumes tick pulses at the doubled rate; lengths are counts of ticks.
`timescale 1ns/100ps
module btg_env #(
   parameter int unsigned INT1_ON = 2048,
   parameter int unsigned INT1_OFF = 2048,
   parameter int unsigned INT2_ON = 1024,
   parameter int unsigned INT2_OFF = 3072,
   parameter int unsigned SINGLE_ON = 4096
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic run,
   input wire logic [1:0] pattern,
   output logic gate_q,
   output logic done_q
);
   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_ON = 4'b0010,
      S_OFF = 4'b0100,
      S_END = 4'b1000
   } btg_env_state_t;

   btg_env_state_t state_q;
   logic [btg_pkg::ENV_W-1:0] cnt_q;

   function automatic logic [btg_pkg::ENV_W-1:0] on_len(input logic [1:0] p);
      unique case (btg_pkg::btg_pattern_t'(p))
         btg_pkg::PAT_INT1: on_len = btg_pkg::ENV_W'(INT1_ON - 1);
         btg_pkg::PAT_INT2: on_len = btg_pkg::ENV_W'(INT2_ON - 1);
         btg_pkg::PAT_SINGLE: on_len = btg_pkg::ENV_W'(SINGLE_ON - 1);
         btg_pkg::PAT_CONT: on_len = '0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         state_q <= S_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               state_q <= S_ON;
               cnt_q <= on_len(pattern); // [RULE4] [RULE14]
            end
            S_ON: begin
               if (tick && pattern != btg_pkg::PAT_CONT) begin // [RULE4]
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else if (pattern == btg_pkg::PAT_SINGLE) begin
                     state_q <= S_END; // [RULE14]
                  end else begin
                     state_q <= S_OFF;
                     cnt_q <= (pattern == btg_pkg::PAT_INT1) ?
                        btg_pkg::ENV_W'(INT1_OFF - 1) : btg_pkg::ENV_W'(INT2_OFF - 1);
                  end
               end
            end
            S_OFF: begin
               if (tick) begin
                  if (cnt_q != '0) begin
                     cnt_q <= cnt_q - 1'b1;
                  end else begin
                     state_q <= S_ON;
                     cnt_q <= on_len(pattern);
                  end
               end
            end
            S_END: state_q <= S_END;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gate_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         gate_q <= run && state_q == S_ON;
         done_q <= run && state_q == S_ON && tick && cnt_q == '0 &&
            pattern == btg_pkg::PAT_SINGLE;
      end
   end
endmodule

// >>> verilog/btg_top.sv
// Buzzer tone generator top: Wishbone registers, tick source, tone, pin select.
// Assumes synchronous pin inputs and a doubled low-speed clock level input.
//
// How it works
// RULE1: Tone drives the pin only while the run bit is one; reset clears it.
// RULE2: Tone timing counts edges of the doubled low-speed clock only.
// RULE3: Software enables the clock doubler before setting run.
// RULE4: Pattern 0 intermittent one, 1 intermittent two, 2 single, 3 continuous.
// RULE5: Pitch code n gives 4.096 kHz divided by n plus one.
// RULE6: Frequencies hold at nominal source rate and scale with it otherwise.
// RULE7: High time is duty code sixteenths; codes 0 and 1 both give one.
// RULE8: Duty applies to the high part; low fills the rest of the period.
// RULE9: Software writes pattern, duty, pitch, doubler enable, then run.
// RULE10: Software selects the buzzer as the shared pin function.
// RULE11: Software sets both drive bits for push-pull output.
// RULE12: Port data bit is ignored while the pin carries the tone.
// RULE13: Pitch and duty reachable as bytes or as one word at pitch.
// RULE14: Envelope lengths are parameters; single pattern stops after one burst.
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
module btg_top #(
   parameter int unsigned INT1_ON_TICKS = 2048,
   parameter int unsigned INT1_OFF_TICKS = 2048,
   parameter int unsigned INT2_ON_TICKS = 1024,
   parameter int unsigned INT2_OFF_TICKS = 3072,
   parameter int unsigned SINGLE_ON_TICKS = 4096
) (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [btg_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [btg_pkg::SEL_W-1:0] WB_SEL_I,
   input wire logic [btg_pkg::DAT_W-1:0] WB_DAT_I,
   output logic [btg_pkg::DAT_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic LOW_SPEED_CLOCK_X2,
   input wire logic CLOCK_DOUBLER_ENABLE,
   input wire logic PIN_ALT_FUNCTION_SELECT,
   input wire logic PIN_DATA_BIT,
   output logic TONE_OUT_PIN,
   output logic SHARED_PORT_PIN
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode
   btg_pkg::btg_cfg_t cfg_q;
   logic ack_q;
   logic [btg_pkg::DAT_W-1:0] rdat_q;
   logic req;
   logic wr_stb;
   logic [15:0] idx;
   logic ctrl_wr;
   logic ls2_q;
   logic tick_q;
   logic tone_lvl;
   logic env_gate;
   logic env_done;
   logic tone_q;
   logic pin_q;

   assign req = WB_CYC_I && WB_STB_I && !ack_q;
   assign wr_stb = req && WB_WE_I;
   assign idx = WB_ADR_I[btg_pkg::ADR_W-1:2];
   assign ctrl_wr = wr_stb && idx == btg_pkg::IDX_CONTROL && WB_SEL_I[btg_pkg::LANE_LO];

   // One wait state: ack lands on the edge after the request is seen
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cfg_q.run <= btg_pkg::REG_RESET[btg_pkg::CTRL_RUN_BIT]; // [RULE1]
      end else if (ctrl_wr) begin
         // Software write wins over the self stop of a single sound
         cfg_q.run <= WB_DAT_I[btg_pkg::CTRL_RUN_BIT]; // [RULE1]
      end else if (env_done) begin
         cfg_q.run <= 1'b0; // [RULE14]
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cfg_q.pattern <= btg_pkg::REG_RESET[1:0];
      end else if (wr_stb && idx == btg_pkg::IDX_PATTERN && WB_SEL_I[btg_pkg::LANE_LO]) begin
         cfg_q.pattern <= WB_DAT_I[btg_pkg::PAT_LSB +: 2]; // [RULE4]
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cfg_q.pitch <= btg_pkg::REG_RESET[2:0];
      end else if (wr_stb && idx == btg_pkg::IDX_PITCH && WB_SEL_I[btg_pkg::LANE_LO]) begin
         cfg_q.pitch <= WB_DAT_I[btg_pkg::PITCH_LSB +: 3]; // [RULE5]
      end
   end

   // Duty has a byte home and a second lane in the pitch word
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         cfg_q.duty <= btg_pkg::REG_RESET[3:0];
      end else if (wr_stb && idx == btg_pkg::IDX_DUTY && WB_SEL_I[btg_pkg::LANE_LO]) begin
         cfg_q.duty <= WB_DAT_I[btg_pkg::DUTY_LSB +: 4]; // [RULE7]
      end else if (wr_stb && idx == btg_pkg::IDX_PITCH && WB_SEL_I[btg_pkg::LANE_HI]) begin
         cfg_q.duty <= WB_DAT_I[btg_pkg::WORD_DUTY_LSB +: 4]; // [RULE13]
      end
   end

   // Read mux; unmapped words ack with zero
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         rdat_q <= btg_pkg::DAT_ZERO;
      end else if (req && !WB_WE_I) begin
         rdat_q <= btg_pkg::DAT_ZERO;
         unique case (idx)
            btg_pkg::IDX_CONTROL: begin
               rdat_q[btg_pkg::CTRL_RUN_BIT] <= cfg_q.run;
               rdat_q[btg_pkg::CTRL_LEVEL_BIT] <= tone_q;
            end
            btg_pkg::IDX_PATTERN: rdat_q[btg_pkg::PAT_LSB +: 2] <= cfg_q.pattern;
            btg_pkg::IDX_PITCH: begin
               rdat_q[btg_pkg::PITCH_LSB +: 3] <= cfg_q.pitch;
               rdat_q[btg_pkg::WORD_DUTY_LSB +: 4] <= cfg_q.duty; // [RULE13]
            end
            btg_pkg::IDX_DUTY: rdat_q[btg_pkg::DUTY_LSB +: 4] <= cfg_q.duty;
            default: rdat_q <= btg_pkg::DAT_ZERO;
         endcase
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdat_q;

   ////////////////////////////////////////////////////////////////////////////
   // Tick source: rising edges of the doubled clock, dead while it is disabled
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ls2_q <= 1'b0;
      end else begin
         ls2_q <= LOW_SPEED_CLOCK_X2;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tick_q <= 1'b0;
      end else begin
         tick_q <= LOW_SPEED_CLOCK_X2 && !ls2_q && CLOCK_DOUBLER_ENABLE; // [RULE2] [RULE3]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tone and envelope
   btg_env #(
      .INT1_ON(INT1_ON_TICKS),
      .INT1_OFF(INT1_OFF_TICKS),
      .INT2_ON(INT2_ON_TICKS),
      .INT2_OFF(INT2_OFF_TICKS),
      .SINGLE_ON(SINGLE_ON_TICKS)
   ) u_env (
      .clk(CLOCK),
      .rst(RST),
      .tick(tick_q),
      .run(cfg_q.run),
      .pattern(cfg_q.pattern),
      .gate_q(env_gate),
      .done_q(env_done)
   );

   btg_tone u_tone (
      .clk(CLOCK),
      .rst(RST),
      .tick(tick_q),
      .enable(cfg_q.run && env_gate),
      .pitch(cfg_q.pitch),
      .duty(cfg_q.duty),
      .level_q(tone_lvl)
   );

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         tone_q <= 1'b0;
      end else begin
         // Doubler off freezes the divider; hold the pin low instead of a stuck level
         tone_q <= tone_lvl && env_gate && cfg_q.run && CLOCK_DOUBLER_ENABLE; // [RULE1] [RULE2]
      end
   end

   assign TONE_OUT_PIN = tone_q;

   ////////////////////////////////////////////////////////////////////////////
   // Shared pin: data bit only reaches the pin when the tone is not selected
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pin_q <= 1'b0;
      end else if (PIN_ALT_FUNCTION_SELECT) begin
         pin_q <= tone_q; // [RULE10] [RULE12]
      end else begin
         pin_q <= PIN_DATA_BIT;
      end
   end

   assign SHARED_PORT_PIN = pin_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   a_run_gates_tone: assert property (!cfg_q.run |=> !tone_q) // [RULE1]
      else $error("tone active with run clear");
   a_tick_needs_dbl: assert property (tick_q |-> // [RULE2]
      $past(CLOCK_DOUBLER_ENABLE) && $past(LOW_SPEED_CLOCK_X2) && !$past(ls2_q))
      else $error("tick without doubled clock edge");
   a_tick_single: assert property (tick_q |=> !tick_q) // [RULE2]
      else $error("tick longer than one cycle");
   a_cont_holds: assert property (cfg_q.pattern == btg_pkg::PAT_CONT && // [RULE4]
      $past(cfg_q.pattern) == btg_pkg::PAT_CONT && cfg_q.run && $past(cfg_q.run) &&
      $past(env_gate) |-> env_gate)
      else $error("continuous pattern dropped its gate");
   a_pitch_word: assert property (wr_stb && idx == btg_pkg::IDX_PITCH && // [RULE13]
      WB_SEL_I[btg_pkg::LANE_HI] |=> cfg_q.duty == $past(WB_DAT_I[11:8]))
      else $error("word write missed duty lane");
   a_pitch_byte: assert property (wr_stb && idx == btg_pkg::IDX_PITCH && // [RULE5]
      WB_SEL_I[btg_pkg::LANE_LO] |=> cfg_q.pitch == $past(WB_DAT_I[2:0]))
      else $error("pitch byte write lost");
   a_pin_ignores: assert property ($past(PIN_ALT_FUNCTION_SELECT) |-> // [RULE12]
      SHARED_PORT_PIN == $past(tone_q))
      else $error("shared pin not carrying tone");
   a_single_stop: assert property (env_done && !ctrl_wr |=> !cfg_q.run) // [RULE14]
      else $error("single sound did not stop");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   a_env_tone: assert property (!env_gate ##1 !env_gate |=> !tone_q) // [RULE4]
      else $error("tone during envelope off time");
   a_dbl_gates_tone: assert property (!CLOCK_DOUBLER_ENABLE |=> !TONE_OUT_PIN) // [RULE2]
      else $error("tone active without doubled clock");

   c_single_done: cover property (env_done);
   c_tone_high: cover property (cfg_q.pattern == btg_pkg::PAT_CONT && tone_q);
   c_int_gap: cover property (cfg_q.run && $fell(env_gate));
   c_word_wr: cover property (wr_stb && idx == btg_pkg::IDX_PITCH && WB_SEL_I[1:0] == 2'h3);
   c_run_no_dbl: cover property (cfg_q.run && !CLOCK_DOUBLER_ENABLE);
endmodule

// >>> dv/btg_piezo.sv
// Piezo model: times the high span and the period of its drive pin.
// Assumes the pin is sampled on the system clock.
`timescale 1ns/100ps
module btg_piezo (
   input wire logic clk,
   input wire logic drive,
   output int high_len,
   output int per_len,
   output logic meas
);
   int hi_q = 0;
   int all_q = 0;
   logic prev_q = 1'b0;
   ////////////////////////////////////////
   // Each rise closes one period of the load
   // Push-pull drive: the pin always shows a firm level
   always @(posedge clk) begin
      prev_q <= drive;
      meas <= drive & ~prev_q;
      if (drive & ~prev_q) begin
         high_len <= hi_q;
         per_len <= all_q;
         hi_q <= 1;
         all_q <= 1;
      end else begin
         hi_q <= hi_q + (drive ? 1 : 0);
         all_q <= all_q + 1;
      end
   end
endmodule

// >>> dv/buzzer_tone_generator_bench.sv
// Bench for the buzzer tone generator: registers, tone timing, patterns, pin.
// Assumes the design package and the piezo model are compiled first.
`timescale 1ns/100ps
module buzzer_tone_generator_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [btg_pkg::ADR_W-1:0] adr = '0;
   logic [btg_pkg::SEL_W-1:0] sel = '0;
   logic [btg_pkg::DAT_W-1:0] wdat = '0;
   logic [btg_pkg::DAT_W-1:0] rdat;
   logic ack, tone, shared, meas;
   logic ls = 1'b0;
   logic dbl_en = 1'b0;
   logic alt_sel = 1'b0;
   logic pdat = 1'b0;
   int ls_half = 4;
   int ls_cnt = 0;
   int high_len, per_len;
   int fail_count = 0;
   int comparisons = 0;
   logic [15:0] rnd = 16'h003C;
   logic [31:0] exp_q[$];
   string name_q[$];
   logic [3:0] dty [8] = '{4'h0, 4'h1, 4'hF, 4'h8, 4'h3, 4'hC, 4'h7, 4'h2};
   logic [31:0] pat_rises [4] = '{32'h8, 32'h4, 32'h3, 32'h10};

   btg_top #(.INT1_ON_TICKS(32), .INT1_OFF_TICKS(32), .INT2_ON_TICKS(16),
      .INT2_OFF_TICKS(48), .SINGLE_ON_TICKS(48)) i_btg_top (
      .CLOCK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .LOW_SPEED_CLOCK_X2(ls), .CLOCK_DOUBLER_ENABLE(dbl_en),
      .PIN_ALT_FUNCTION_SELECT(alt_sel), .PIN_DATA_BIT(pdat),
      .TONE_OUT_PIN(tone), .SHARED_PORT_PIN(shared));
   btg_piezo i_btg_piezo (.clk(clk), .drive(tone), .high_len(high_len),
      .per_len(per_len), .meas(meas));

   ////////////////////////////////////////
   // Clocks; the doubled clock runs fast so tone periods stay short
   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (ls_cnt >= ls_half - 1) begin
         ls_cnt <= 0;
         ls <= ~ls;
      end else
         ls_cnt <= ls_cnt + 1;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] e);
      comparisons++;
      if (seen !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, seen);
      end
   endtask

   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////
   // Classic Wishbone single cycle; the watchdog bounds a hang
   task automatic wb(input logic w, input logic [15:0] idx, input logic [3:0] s,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'h0};
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      check("ack wait", 32'(n), 32'h2);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] idx, input logic [31:0] e, input string nm);
      exp_q.push_back(e);
      name_q.push_back(nm);
      wb(1'b0, idx, 4'h3, 32'h0);
   endtask

   // Read data checked against the oldest note when ack shows
   always @(posedge clk) begin
      if (ack === 1'b1 && cyc && !we && exp_q.size() > 0)
         check(name_q.pop_front(), rdat, exp_q.pop_front());
   end

   task automatic rises(input int cn, output int n);
      logic p;
      p = tone;
      n = 0;
      repeat (cn) begin
         @(posedge clk);
         if (tone === 1'b1 && p !== 1'b1)
            n++;
         p = tone;
      end
   endtask

   task automatic measure(output int h, output int p);
      int k, n;
      k = 0;
      n = 0;
      // First period opens mid-tick; the third rise closes a full one
      while (k < 3 && n < 5000) begin
         @(posedge clk);
         n++;
         if (meas === 1'b1)
            k++;
      end
      check("tone wait", {31'h0, n < 5000}, 32'h1);
      h = high_len;
      p = per_len;
   endtask

   // Shared pin follows port data unless the tone owns it
   task automatic pin_watch(input int n);
      logic e, t;
      @(posedge clk);
      e = alt_sel ? tone : pdat;
      repeat (n) begin
         rnd = lfsr(rnd);
         pdat <= rnd[0];
         t = tone;
         @(posedge clk);
         check("shared pin", {31'h0, shared === e || (alt_sel && shared === t)},
            32'h1);
         e = alt_sel ? tone : pdat;
      end
   endtask

   initial begin
      repeat (90000) @(posedge clk);
      fail_count++;
      stop_test();
   end

   initial begin
      int h, p, n;
      logic [3:0] d;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++)
         rd(btg_pkg::IDX_CONTROL + 16'(i), 32'h0, "reset value");
      wb(1'b1, btg_pkg::IDX_PATTERN, 4'h1, 32'hFF);
      rd(btg_pkg::IDX_PATTERN, 32'h3, "pattern");
      wb(1'b1, 16'hF2C4, 4'h1, 32'hFF);
      rd(16'hF2C4, 32'h0, "unmapped");
      repeat (3) begin
         rnd = lfsr(rnd);
         wb(1'b1, btg_pkg::IDX_PITCH, 4'h3, {16'h0, rnd});
         rd(btg_pkg::IDX_PITCH, {20'h0, rnd[11:8], 5'h0, rnd[2:0]}, "word");
         rd(btg_pkg::IDX_DUTY, {28'h0, rnd[11:8]}, "duty");
         wb(1'b1, btg_pkg::IDX_DUTY, 4'h1, {24'h0, rnd[7:0]});
         rd(btg_pkg::IDX_PITCH, {20'h0, rnd[3:0], 5'h0, rnd[2:0]}, "byte duty");
      end
      pin_watch(40);
      alt_sel <= 1'b1;
      pin_watch(40);
      // Setup order: pattern, duty, pitch, doubler, run
      wb(1'b1, btg_pkg::IDX_PATTERN, 4'h1, 32'h3);
      for (int i = 0; i < 8; i++) begin
         d = dty[i];
         wb(1'b1, btg_pkg::IDX_DUTY, 4'h1, {28'h0, d});
         wb(1'b1, btg_pkg::IDX_PITCH, 4'h1, 32'(i));
         dbl_en <= 1'b1;
         wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h1);
         measure(h, p);
         check("high", 32'(h), 32'((d == 4'h0 ? 1 : d) * (i + 1) * 8));
         check("period", 32'(p), 32'(16 * (i + 1) * 8));
         if (i == 7)
            pin_watch(400);
         wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h0);
      end
      rises(500, n);
      check("stopped", 32'(n), 32'h0);
      dbl_en <= 1'b0;
      wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h1);
      rises(500, n);
      check("no doubler", 32'(n), 32'h0);
      wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h0);
      dbl_en <= 1'b1;
      wb(1'b1, btg_pkg::IDX_PITCH, 4'h3, 32'h0800);
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, btg_pkg::IDX_PATTERN, 4'h1, 32'(k));
         wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h1);
         rises(2000, n);
         check("pattern rises", 32'(n), pat_rises[k]);
         if (k == 2)
            rd(btg_pkg::IDX_CONTROL, 32'h0, "single stop");
         wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h0);
         repeat (20) @(posedge clk);
      end
      // Slower source stretches the tone in proportion
      ls_half = 6;
      wb(1'b1, btg_pkg::IDX_PITCH, 4'h3, 32'h0801);
      wb(1'b1, btg_pkg::IDX_CONTROL, 4'h1, 32'h1);
      measure(h, p);
      check("scaled high", 32'(h), 32'(8 * 2 * 12));
      check("scaled period", 32'(p), 32'(16 * 2 * 12));
      stop_test();
   end
endmodule
